// ### verilog/wwd_watchdog.sv
`timescale 1ns/1ns
// Functional notes
// - watchdog runs on rc clock, enabled with it
// - prescaler divides rc clock by 32 or 128
// - postscaler divides further, sixteen ratios
// - completed clock switch clears all counts
// - entering sleep or idle clears counts
// - leaving sleep or idle clears counts
// - clear instruction in run clears counts
// - enabled watchdog keeps counting while asleep
// - time-out while asleep wakes, no reset
// - force bit keeps watchdog always enabled
// - otherwise software enable bit controls watchdog
// - software enable cleared by device reset
// - time-out flag sticky, software clears it
// - window disable low selects windowed mode
// - window select gives 25/50/62.5/75 percent
// - prescale select one means divide 128
// - postscale select is power of two
// - force bit blocks software disabling
module wwd_watchdog (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [15:0] config_word_i,
  input wire logic dev_reset_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic power_save_instr_i,
  input wire logic power_save_idle_i,
  input wire logic wake_other_i,
  input wire logic clock_switch_done_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic low_power_rc_enable_o,
  output logic wdt_reset_o,
  output logic wake_o,
  output logic [1:0] power_mode_o
);

  typedef struct packed {
    logic [6:0] presc_cnt;
    logic [14:0] post_cnt;
    logic sw_en;
    logic flag;
    logic sleep_bit;
    logic idle_bit;
    wwd_pkg::wwd_mode_t mode;
    logic [15:0] rdata;
    logic rst_pulse;
    logic wake_pulse;
  } wwd_state_t;

  wwd_state_t st;
  wwd_state_t next_st;

  // ==========================================================
  // configuration decode
  function automatic logic [2:0] wwd_win_eighths(input logic [1:0] sel);
    case (sel)
      2'b11: wwd_win_eighths = wwd_pkg::WIN_OPEN_SEL11;
      2'b10: wwd_win_eighths = wwd_pkg::WIN_OPEN_SEL10;
      2'b01: wwd_win_eighths = wwd_pkg::WIN_OPEN_SEL01;
      default: wwd_win_eighths = wwd_pkg::WIN_OPEN_SEL00;
    endcase
  endfunction

  logic [3:0] post_sel;
  logic presc_sel;
  logic win_off;
  logic force_en;
  logic [1:0] win_sel;
  assign post_sel = config_word_i[wwd_pkg::CFG_POST_LSB +: 4];
  assign presc_sel = config_word_i[wwd_pkg::CFG_PRESC_BIT];
  assign win_off = config_word_i[wwd_pkg::CFG_WINOFF_BIT];
  assign force_en = config_word_i[wwd_pkg::CFG_FORCE_BIT];
  assign win_sel = config_word_i[wwd_pkg::CFG_WIN_LSB +: 2];

  logic wdt_en;
  logic tick;
  assign wdt_en = force_en | st.sw_en;
  assign low_power_rc_enable_o = wdt_en;

  wwd_rc_tick u_tick (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .enable_i(wdt_en),
    .tick_o(tick)
  );

  // ==========================================================
  // terminal counts and window position
  logic [2:0] shift;
  logic [6:0] presc_last;
  logic [14:0] post_mask;
  logic [22:0] elapsed;
  logic [22:0] period;
  logic [22:0] win_open;
  always_comb begin
    shift = presc_sel ? wwd_pkg::PRESC_SHIFT_LARGE : wwd_pkg::PRESC_SHIFT_SMALL;
    presc_last = presc_sel ? wwd_pkg::PRESC_LAST_LARGE : wwd_pkg::PRESC_LAST_SMALL;
    post_mask = 15'(16'(16'h0001 << post_sel) - 16'h0001);
    elapsed = ({8'h00, st.post_cnt} << shift) | {16'h0000, st.presc_cnt};
    period = 23'(23'h000001 << (5'(shift) + 5'(post_sel)));
    // period is a multiple of 32, so eighths are exact
    win_open = 23'((period >> 3) * {20'h00000, wwd_win_eighths(win_sel)});
  end

  logic presc_wrap;
  logic expire;
  logic in_run;
  logic clr_run;
  logic violation;
  logic enter_ps;
  logic exit_ps;
  logic own_reset;
  logic clear_cnt;
  logic rc_wr;
  assign presc_wrap = st.presc_cnt == presc_last;
  assign expire = wdt_en & tick & presc_wrap & (st.post_cnt == post_mask);
  assign in_run = st.mode == wwd_pkg::WWD_RUN;
  assign clr_run = clear_watchdog_instr_i & in_run;
  // windowed mode only when window_disable is low
  assign violation = wdt_en & clr_run & ~win_off & (elapsed < win_open);
  assign enter_ps = power_save_instr_i & in_run;
  assign exit_ps = ~in_run & (wake_other_i | expire);
  assign own_reset = (expire & in_run) | violation;
  assign clear_cnt = dev_reset_i | clock_switch_done_i
                   | clr_run | enter_ps
                   | exit_ps | expire | ~wdt_en;
  assign rc_wr = wr_i & (addr_i == wwd_pkg::ADDR_RESET_CAUSE);

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.rst_pulse = own_reset;
    next_st.wake_pulse = expire & ~in_run;
    // counting is independent of mode, so sleep keeps counting
    if (clear_cnt) begin
      next_st.presc_cnt = 7'h00;
      next_st.post_cnt = 15'h0000;
    end else if (tick) begin
      if (presc_wrap) begin
        next_st.presc_cnt = 7'h00;
        next_st.post_cnt = st.post_cnt + 15'h0001;
      end else begin
        next_st.presc_cnt = st.presc_cnt + 7'h01;
      end
    end
    // software writes first, hardware sets override
    if (rc_wr) begin
      if (wdata_i[wwd_pkg::RC_SWEN_BIT] || !force_en) begin
        next_st.sw_en = wdata_i[wwd_pkg::RC_SWEN_BIT];
      end
      next_st.flag = wdata_i[wwd_pkg::RC_FLAG_BIT];
      next_st.sleep_bit = wdata_i[wwd_pkg::RC_SLEEP_BIT];
      next_st.idle_bit = wdata_i[wwd_pkg::RC_IDLE_BIT];
    end
    if (expire || violation) begin
      next_st.flag = 1'b1;
    end
    if (dev_reset_i || own_reset) begin
      next_st.sw_en = 1'b0;
    end
    // sleep and idle bits stay set after wake-up
    case (st.mode)
      wwd_pkg::WWD_RUN: begin
        if (enter_ps && !own_reset) begin
          if (power_save_idle_i) begin
            next_st.mode = wwd_pkg::WWD_IDLE;
            next_st.idle_bit = 1'b1;
          end else begin
            next_st.mode = wwd_pkg::WWD_SLEEP;
            next_st.sleep_bit = 1'b1;
          end
        end
      end
      wwd_pkg::WWD_SLEEP, wwd_pkg::WWD_IDLE: begin
        if (exit_ps) begin
          next_st.mode = wwd_pkg::WWD_RUN;
        end
      end
      default: begin
        next_st.mode = wwd_pkg::WWD_RUN;
      end
    endcase
    if (dev_reset_i) begin
      next_st.mode = wwd_pkg::WWD_RUN;
    end
    // read data valid for exactly one cycle
    next_st.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        wwd_pkg::ADDR_RESET_CAUSE: begin
          next_st.rdata[wwd_pkg::RC_SWEN_BIT] = st.sw_en;
          next_st.rdata[wwd_pkg::RC_FLAG_BIT] = st.flag;
          next_st.rdata[wwd_pkg::RC_SLEEP_BIT] = st.sleep_bit;
          next_st.rdata[wwd_pkg::RC_IDLE_BIT] = st.idle_bit;
        end
        wwd_pkg::ADDR_COUNT_STATUS: begin
          next_st.rdata = {1'b0, st.post_cnt};
        end
        default: begin
          next_st.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
      st.mode <= wwd_pkg::WWD_RUN;
      st.sw_en <= wwd_pkg::RESET_CAUSE_RST[wwd_pkg::RC_SWEN_BIT];
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign wdt_reset_o = st.rst_pulse;
  assign wake_o = st.wake_pulse;
  assign power_mode_o = st.mode;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  rc_enable_a: assert property (force_en |-> low_power_rc_enable_o)
    else $error("rc oscillator off while watchdog forced");
  presc_wrap_a: assert property (tick && presc_wrap && !clear_cnt
      |=> st.presc_cnt == 7'h00 && st.post_cnt == $past(st.post_cnt) + 15'h0001)
    else $error("prescaler did not wrap into postscaler");
  post_range_a: assert property (wdt_en && !$changed(config_word_i)
      |-> st.post_cnt <= post_mask)
    else $error("postscaler beyond selected ratio");
  clr_instr_a: assert property (clr_run
      |=> st.presc_cnt == 7'h00 && st.post_cnt == 15'h0000)
    else $error("clear instruction left counts");
  switch_clr_a: assert property (clock_switch_done_i
      |=> st.presc_cnt == 7'h00 && st.post_cnt == 15'h0000)
    else $error("clock switch left counts");
  enter_ps_a: assert property (enter_ps && !own_reset && !dev_reset_i
      |=> st.mode != wwd_pkg::WWD_RUN && st.presc_cnt == 7'h00)
    else $error("power save entry wrong");
  sleep_count_a: assert property (!in_run && tick && !presc_wrap && !clear_cnt
      |=> st.presc_cnt == $past(st.presc_cnt) + 7'h01)
    else $error("watchdog stalled in power save");
  wake_out_a: assert property (expire && !in_run && !dev_reset_i
      |=> wake_o && !wdt_reset_o && in_run ##1 !wake_o)
    else $error("wake from time-out wrong");
  swen_clear_a: assert property (dev_reset_i |=> !st.sw_en)
    else $error("software enable survived reset");
  flag_sticky_a: assert property (st.flag && !rc_wr |=> st.flag)
    else $error("time-out flag cleared by hardware");
  force_keep_a: assert property (force_en && st.sw_en && !dev_reset_i && !own_reset
      |=> st.sw_en)
    else $error("software enable cleared under force");
  timeout_rst_a: assert property (expire && in_run
      |=> wdt_reset_o && st.flag ##1 !wdt_reset_o)
    else $error("run time-out did not reset");
  early_clr_a: assert property (violation
      |=> wdt_reset_o && st.flag)
    else $error("early clear not treated as violation");
  // a clear at or after the open point is legal
  late_clr_a: assert property (clr_run && wdt_en && !win_off && !expire
      && elapsed >= win_open |=> !wdt_reset_o)
    else $error("clear inside window caused reset");
  dev_clr_a: assert property (dev_reset_i
      |=> st.presc_cnt == 7'h00 && st.post_cnt == 15'h0000 && in_run)
    else $error("device reset left counts or mode");
  exit_clr_a: assert property (exit_ps
      |=> st.presc_cnt == 7'h00 && st.post_cnt == 15'h0000 && in_run)
    else $error("power save exit left counts");
  ps_bits_a: assert property (enter_ps && !own_reset && !dev_reset_i
      |=> ($past(power_save_idle_i) ? st.idle_bit : st.sleep_bit))
    else $error("power save status bit not set");
  ps_hold_a: assert property (!in_run && !exit_ps && !dev_reset_i
      |=> !in_run)
    else $error("left power save without wake");
  presc_range_a: assert property (wdt_en && !$changed(config_word_i)
      |-> st.presc_cnt <= (presc_sel ? wwd_pkg::PRESC_LAST_LARGE : wwd_pkg::PRESC_LAST_SMALL))
    else $error("prescaler beyond selected ratio");
  off_quiet_a: assert property (!wdt_en
      |=> st.presc_cnt == 7'h00 && st.post_cnt == 15'h0000 && !wdt_reset_o && !wake_o)
    else $error("disabled watchdog counted or fired");
  flag_set_a: assert property (expire || violation
      |=> st.flag)
    else $error("time-out flag not set");

  run_timeout_c: cover property (expire && in_run);
  sleep_wake_c: cover property (expire && !in_run);
  window_viol_c: cover property (violation);
  good_clear_c: cover property (clr_run && !win_off && !violation && wdt_en);
  idle_exit_c: cover property (exit_ps && wake_other_i);

endmodule

// ### verilog/wwd_pkg.sv
package wwd_pkg;

  // ==========================================================
  // clocking and the emulated low-power rc rate
  localparam int unsigned CLK_FREQ_HZ = 100000000;
  localparam int unsigned RC_FREQ_HZ = 32000;
  localparam int unsigned RC_TICK_CYCLES = CLK_FREQ_HZ / RC_FREQ_HZ;
  localparam logic [11:0] RC_TICK_LAST = 12'(RC_TICK_CYCLES - 1);

  // ==========================================================
  // prescaler: divide by 32 or by 128
  localparam logic [2:0] PRESC_SHIFT_SMALL = 3'h5;
  localparam logic [2:0] PRESC_SHIFT_LARGE = 3'h7;
  localparam logic [6:0] PRESC_LAST_SMALL = 7'h1f;
  localparam logic [6:0] PRESC_LAST_LARGE = 7'h7f;

  // ==========================================================
  // watchdog_config_word field positions
  localparam int CFG_POST_LSB = 0;
  localparam int CFG_PRESC_BIT = 4;
  localparam int CFG_WINOFF_BIT = 6;
  localparam int CFG_FORCE_BIT = 7;
  localparam int CFG_WIN_LSB = 8;

  // window opening point, in eighths of the period
  localparam logic [2:0] WIN_OPEN_SEL11 = 3'h6;
  localparam logic [2:0] WIN_OPEN_SEL10 = 3'h5;
  localparam logic [2:0] WIN_OPEN_SEL01 = 3'h4;
  localparam logic [2:0] WIN_OPEN_SEL00 = 3'h2;

  // ==========================================================
  // register map
  localparam logic [3:0] ADDR_RESET_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_COUNT_STATUS = 4'h1;
  localparam int RC_IDLE_BIT = 2;
  localparam int RC_SLEEP_BIT = 3;
  localparam int RC_FLAG_BIT = 4;
  localparam int RC_SWEN_BIT = 5;
  localparam logic [15:0] RESET_CAUSE_RST = 16'h0000;

  typedef enum logic [1:0] {
    WWD_RUN = 2'b00,
    WWD_SLEEP = 2'b01,
    WWD_IDLE = 2'b10
  } wwd_mode_t;

endpackage

// ### verilog/wwd_low_power_rc_clock_tick.sv
`timescale 1ns/1ns
module wwd_rc_tick (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  output logic tick_o
);

  typedef struct packed {
    logic [11:0] cnt;
    logic tick;
  } wwd_tick_state_t;

  wwd_tick_state_t st;
  wwd_tick_state_t next_st;

  // stopped oscillator restarts from a full period
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!enable_i) begin
      next_st.cnt = 12'h000;
    end else if (st.cnt == wwd_pkg::RC_TICK_LAST) begin
      next_st.cnt = 12'h000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 12'h001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;

endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // ==========================================================
  // stimulus and observed signals
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [15:0] cfg = 16'h0040;
  logic dev_rst = 1'b0;
  logic [3:0] ev = 4'h0;
  logic idle_sel = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic rc_en;
  logic wdt_rst;
  logic wake;
  logic [1:0] mode;
  int errors = 0;
  int num_checks = 0;
  int rst_cnt = 0;
  int wake_cnt = 0;
  logic [31:0] seed = 32'h34ae;

  always #5 clk_sys_i = ~clk_sys_i;

  wwd_watchdog wwd_watchdog_i (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .config_word_i(cfg),
    .dev_reset_i(dev_rst),
    .clear_watchdog_instr_i(ev[0]),
    .power_save_instr_i(ev[1]),
    .power_save_idle_i(idle_sel),
    .wake_other_i(ev[2]),
    .clock_switch_done_i(ev[3]),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_i(wr),
    .rd_i(rd),
    .rdata_o(rdata),
    .low_power_rc_enable_o(rc_en),
    .wdt_reset_o(wdt_rst),
    .wake_o(wake),
    .power_mode_o(mode)
  );

  // pulses are one cycle wide, so one sample per edge counts each once
  always @(posedge clk_sys_i) begin
    if (wdt_rst === 1'b1) rst_cnt++;
    if (wake === 1'b1) wake_cnt++;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] cfg_w(logic hw_force, logic win_off, logic [1:0] win);
    logic [15:0] c;
    c = 16'h0000;
    c[wwd_pkg::CFG_FORCE_BIT] = hw_force;
    c[wwd_pkg::CFG_WINOFF_BIT] = win_off;
    c[wwd_pkg::CFG_WIN_LSB +: 2] = win;
    return c;
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(logic [15:0] seen, logic [15:0] exp, string msg);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic rd_chk(logic [3:0] a, logic [15:0] exp);
    @(posedge clk_sys_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 check(rdata, exp, "read data");
    @(posedge clk_sys_i);
    #1 check(rdata, 16'h0000, "read data after its cycle");
  endtask

  task automatic wr_reg(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    #1;
  endtask

  task automatic pulse(int k);
    @(posedge clk_sys_i);
    ev[k] <= 1'b1;
    @(posedge clk_sys_i);
    ev[k] <= 1'b0;
    #1;
  endtask

  // fuse bits only change while the part is held in reset
  task automatic do_reset(logic [15:0] c);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    cfg <= c;
    repeat (10) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
  endtask

  // ==========================================================
  // scenarios
  initial begin
    logic [15:0] d;
    logic [3:0] a;
    int r0;
    int w0;
    int t;
    do_reset(cfg_w(1'b0, 1'b1, 2'h0));
    check({15'h0, rc_en}, 16'h0000, "rc enable after reset");
    rd_chk(wwd_pkg::ADDR_RESET_CAUSE, wwd_pkg::RESET_CAUSE_RST);
    rd_chk(wwd_pkg::ADDR_COUNT_STATUS, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      d = 16'(xs());
      a = 4'h2 + 4'(xs() % 14);
      wr_reg(wwd_pkg::ADDR_RESET_CAUSE, d);
      check({15'h0, rc_en}, {15'h0, d[5]}, "rc enable follows sw enable");
      wr_reg(a, ~d);
      pulse(3);
      rd_chk(a, 16'h0000);
      rd_chk(wwd_pkg::ADDR_RESET_CAUSE, d & 16'h003c);
    end
    wr_reg(wwd_pkg::ADDR_RESET_CAUSE, 16'h0030);
    @(posedge clk_sys_i);
    dev_rst <= 1'b1;
    @(posedge clk_sys_i);
    dev_rst <= 1'b0;
    rd_chk(wwd_pkg::ADDR_RESET_CAUSE, 16'h0010);
    check({15'h0, rc_en}, 16'h0000, "rc enable after device reset");
    do_reset(cfg_w(1'b1, 1'b1, 2'h0));
    check({15'h0, rc_en}, 16'h0001, "forced enable");
    wr_reg(wwd_pkg::ADDR_RESET_CAUSE, 16'h0020);
    wr_reg(wwd_pkg::ADDR_RESET_CAUSE, 16'h0000);
    check({15'h0, rc_en}, 16'h0001, "forced enable kept");
    rd_chk(wwd_pkg::ADDR_RESET_CAUSE, 16'h0020);
    r0 = rst_cnt;
    pulse(0);
    repeat (5) @(posedge clk_sys_i);
    check(16'(rst_cnt - r0), 16'h0000, "early clear outside window mode");
    for (int w = 0; w < 4; w++) begin
      do_reset(cfg_w(1'b0, 1'b0, 2'(w)));
      wr_reg(wwd_pkg::ADDR_RESET_CAUSE, 16'h0020);
      r0 = rst_cnt;
      pulse(0);
      repeat (4) @(posedge clk_sys_i);
      check(16'(rst_cnt - r0), 16'h0001, "early clear in window mode");
      rd_chk(wwd_pkg::ADDR_RESET_CAUSE, 16'h0010);
      rd_chk(wwd_pkg::ADDR_COUNT_STATUS, 16'h0000);
    end
    do_reset(cfg_w(1'b0, 1'b0, 2'h0));
    wr_reg(wwd_pkg::ADDR_RESET_CAUSE, 16'h0020);
    @(posedge clk_sys_i);
    idle_sel <= 1'b1;
    pulse(1);
    check({14'h0, mode}, {14'h0, wwd_pkg::WWD_IDLE}, "idle entry");
    rd_chk(wwd_pkg::ADDR_RESET_CAUSE, 16'h0024);
    r0 = rst_cnt;
    pulse(0);
    pulse(2);
    check({14'h0, mode}, {14'h0, wwd_pkg::WWD_RUN}, "idle exit");
    check(16'(rst_cnt - r0), 16'h0000, "clear ignored while idle");
    pulse(0);
    repeat (4) @(posedge clk_sys_i);
    check(16'(rst_cnt - r0), 16'h0001, "counts cleared on exit");
    do_reset(cfg_w(1'b0, 1'b1, 2'h0));
    wr_reg(wwd_pkg::ADDR_RESET_CAUSE, 16'h0020);
    @(posedge clk_sys_i);
    idle_sel <= 1'b0;
    pulse(1);
    check({14'h0, mode}, {14'h0, wwd_pkg::WWD_SLEEP}, "sleep entry");
    w0 = wake_cnt;
    r0 = rst_cnt;
    t = 0;
    while (wake_cnt == w0 && t < 104000) begin
      @(posedge clk_sys_i);
      t++;
    end
    // one period is 32 prescaler steps of 3125 cycles at post ratio 1:1
    check({15'h0, t >= 96000}, 16'h0001, "time-out too early");
    check(16'(wake_cnt - w0), 16'h0001, "wake on time-out");
    check(16'(rst_cnt - r0), 16'h0000, "no reset on sleep time-out");
    #1 check({14'h0, mode}, {14'h0, wwd_pkg::WWD_RUN}, "resumed after wake");
    rd_chk(wwd_pkg::ADDR_RESET_CAUSE, 16'h0038);
    wr_reg(wwd_pkg::ADDR_RESET_CAUSE, 16'h0020);
    rd_chk(wwd_pkg::ADDR_RESET_CAUSE, 16'h0020);
    print_verdict();
  end

  // one sleep period dominates the run, about a millisecond
  initial begin
    #1200000;
    errors++;
    print_verdict();
  end
endmodule
